// ===== design/divshift_defines.vh
/*
  constants for the divide and double shift unit: opcodes, widths, timing.
  assumes inclusion by bare name from design files only.
*/
`ifndef DIVSHIFT_DEFINES_VH
`define DIVSHIFT_DEFINES_VH
`define OP_UNSIGNED_DIVIDE      2'h0
`define OP_SIGNED_LONG_DIVIDE   2'h1
`define OP_SIGN_EXTEND_DIVIDE   2'h2
`define OP_PAIR_LOGICAL_SHIFT   2'h3
`define WORD_W                  16
`define COUNT_HI                7
`define COUNT_LO                0
`define SHIFT_MAX               8'h1f
`define DIV_STEPS               5'h10
`endif

// ===== design/divide_and_double_shift_unit.v
/*
  divide and double shift unit: iterative 32/16 unsigned and signed divide,
  sign-extend-then-divide, and the 32-bit pair logical shift.
  assumes the sequencer presents the four accumulators and carry with a
  one-cycle start pulse, holds them stable until done_o, and writes back
  the returned accumulators and carry when done_o is high.
  a start while busy, or in the last divide cycle, is ignored.
  a signed overflow caught after the loop returns the computed words
  with carry set; software must treat those words as unpredictable.
  the pair shift takes one cycle; a divide takes eighteen from start to
  done_o, trading speed for a single restoring subtractor.
  the sign-extend form copies the sign (most significant) bit of acc1.
  the shift count is the low byte of the source accumulator.
  a zero divisor always takes the overflow path.
*/
// Functional notes
// - unsigned dividend acc0:acc1 over acc2
// - unsigned success: quotient acc1, remainder acc0
// - acc0 >= acc2 unsigned: carry, unchanged
// - signed 32-bit dividend over 16-bit divisor
// - algebraic quotient sign, remainder dividend sign
// - signed success: results, carry clear, acc2 kept
// - signed quotient overflow sets carry, terminates
// - extend acc1 bit 0 into acc0 first; code copies acc1 bit 15
// - extended divide overflow sets carry, aborts
// - pair is dest high, next low, wraps
// - source bits 8-15 signed count, direction; code uses bits 0-7
// - shift by magnitude, zero fill
// - magnitude above 31 clears pair
// - shift keeps carry and source unless overwritten
`timescale 1ns/1ns
`include "divshift_defines.vh"
module divide_and_double_shift_unit #(
  parameter WORD_W = `WORD_W
) (
  // clock and reset
  input  wire              ref_clk_i,
  input  wire              rstn_i,
  // request
  input  wire              start_i,
  input  wire [1:0]        op_i,
  input  wire [1:0]        src_sel_i,
  input  wire [1:0]        dst_sel_i,
  input  wire [WORD_W-1:0] acc0_i,
  input  wire [WORD_W-1:0] acc1_i,
  input  wire [WORD_W-1:0] acc2_i,
  input  wire [WORD_W-1:0] acc3_i,
  input  wire              carry_i,
  // answer
  output reg               busy_o,
  output reg               done_o,
  output reg  [WORD_W-1:0] acc0_o,
  output reg  [WORD_W-1:0] acc1_o,
  output reg  [WORD_W-1:0] acc2_o,
  output reg  [WORD_W-1:0] acc3_o,
  output reg               carry_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DIV  = 2'h1;
  localparam ST_FIN  = 2'h2;
  localparam N_ACC   = 4;

  function [WORD_W-1:0] pick;
    input [1:0]        sel;
    input [WORD_W-1:0] a0;
    input [WORD_W-1:0] a1;
    input [WORD_W-1:0] a2;
    input [WORD_W-1:0] a3;
    begin
      case (sel)
        2'h0:    pick = a0;
        2'h1:    pick = a1;
        2'h2:    pick = a2;
        default: pick = a3;
      endcase
    end
  endfunction

  function [WORD_W-1:0] negw;
    input [WORD_W-1:0] v;
    begin
      negw = ~v + {{(WORD_W-1){1'b0}}, 1'b1};
    end
  endfunction

  function [WORD_W-1:0] absval;
    input [WORD_W-1:0] v;
    begin
      absval = v[WORD_W-1] ? negw(v) : v;
    end
  endfunction

  // both signed forms share the magnitude path and the sign fix-up
  function signed_op;
    input [1:0] op;
    begin
      signed_op = (op == `OP_SIGNED_LONG_DIVIDE) || (op == `OP_SIGN_EXTEND_DIVIDE);
    end
  endfunction

  reg  [1:0]          state_q;
  reg  [1:0]          op_q;
  reg  [WORD_W-1:0]   rem_q;
  reg  [WORD_W-1:0]   quo_q;
  reg  [WORD_W-1:0]   dvs_q;
  reg  [4:0]          step_q;
  reg                 qneg_q;
  reg                 rneg_q;
  reg  [WORD_W-1:0]   rem_d;
  reg  [WORD_W-1:0]   quo_d;
  reg  [WORD_W-1:0]   a2_q;
  reg  [WORD_W-1:0]   a3_q;

  // extended dividend high word
  wire [WORD_W-1:0] hi_w = (op_i == `OP_SIGN_EXTEND_DIVIDE) ?
                           {WORD_W{acc1_i[WORD_W-1]}} : acc0_i;
  wire              sgn_w = signed_op(op_i);
  wire              dneg_w = sgn_w & hi_w[WORD_W-1];
  wire              vneg_w = sgn_w & acc2_i[WORD_W-1];
  // magnitude of 32-bit dividend
  wire [2*WORD_W-1:0] dvd_w = {hi_w, acc1_i};
  wire [2*WORD_W-1:0] dmag_w = dneg_w ? (~dvd_w + {{(2*WORD_W-1){1'b0}}, 1'b1})
                                      : dvd_w;
  wire [WORD_W-1:0] vmag_w = sgn_w ? absval(acc2_i) : acc2_i;
  // unsigned precheck; signed uses magnitudes, zero divisor always overflows
  wire pre_ovf_w = (dmag_w[2*WORD_W-1:WORD_W] >= vmag_w);

  // one restoring step
  wire [WORD_W:0]   trial_w = {rem_q, quo_q[WORD_W-1]} - {1'b0, dvs_q};
  wire              fits_w  = ~trial_w[WORD_W];

  // signed result correction
  wire [WORD_W-1:0] qs_w = qneg_q ? negw(quo_q) : quo_q;
  wire [WORD_W-1:0] rs_w = rneg_q ? negw(rem_q) : rem_q;
  // zero results become positive zero naturally; only a nonzero quotient counts as negative for overflow
  wire              qneg_eff_w = qneg_q & (quo_q != {WORD_W{1'b0}});
  wire              sovf_w = signed_op(op_q) &&
                             (qneg_eff_w ? (quo_q > {1'b1, {(WORD_W-1){1'b0}}})
                                         : quo_q[WORD_W-1]);

  // pair shift
  wire [WORD_W-1:0] src_w = pick(src_sel_i, acc0_i, acc1_i, acc2_i, acc3_i);
  wire [1:0]        low_sel_w = dst_sel_i + 2'h1;
  wire [7:0]        cnt_w = src_w[`COUNT_HI:`COUNT_LO];
  wire [7:0]        mag_w = cnt_w[7] ? (~cnt_w + 8'h01) : cnt_w;
  wire [2*WORD_W-1:0] pair_w = {pick(dst_sel_i, acc0_i, acc1_i, acc2_i, acc3_i),
                               pick(low_sel_w, acc0_i, acc1_i, acc2_i, acc3_i)};
  wire [2*WORD_W-1:0] shl_w = pair_w << mag_w[4:0];
  wire [2*WORD_W-1:0] shr_w = pair_w >> mag_w[4:0];
  wire [2*WORD_W-1:0] sh_w  = (mag_w > `SHIFT_MAX) ? {2*WORD_W{1'b0}} :
                              cnt_w[7] ? shr_w : shl_w;

  // per-accumulator shift result: the pair takes the shifted words and
  // the rest pass through, so a source inside the pair is overwritten
  wire [WORD_W-1:0] acc_in_w [0:N_ACC-1];
  wire [WORD_W-1:0] shv_w    [0:N_ACC-1];
  assign acc_in_w[0] = acc0_i;
  assign acc_in_w[1] = acc1_i;
  assign acc_in_w[2] = acc2_i;
  assign acc_in_w[3] = acc3_i;
  genvar gi;
  generate
    for (gi = 0; gi < N_ACC; gi = gi + 1) begin : g_shv
      assign shv_w[gi] = (dst_sel_i == gi) ? sh_w[2*WORD_W-1:WORD_W] :
                         (low_sel_w == gi) ? sh_w[WORD_W-1:0] : acc_in_w[gi];
    end
  endgenerate

  // taken only from idle; a start during the last divide cycle is dropped
  wire take_w   = (state_q == ST_IDLE) & start_i;
  wire shift_w  = take_w & (op_i == `OP_PAIR_LOGICAL_SHIFT);
  wire ovf_w    = take_w & ~shift_w & pre_ovf_w;
  wire div_go_w = take_w & ~shift_w & ~pre_ovf_w;

  // final results: signed forms get their signs restored
  wire [WORD_W-1:0] rem_res_w = signed_op(op_q) ? rs_w : rem_q;
  wire [WORD_W-1:0] quo_res_w = signed_op(op_q) ? qs_w : quo_q;

  // next remainder and quotient: load magnitudes, then one restoring step
  always @* begin
    rem_d = rem_q;
    quo_d = quo_q;
    case (state_q)
      ST_IDLE: begin
        if (take_w) begin
          rem_d = dmag_w[2*WORD_W-1:WORD_W];
          quo_d = dmag_w[WORD_W-1:0];
        end
      end
      ST_DIV: begin
        // magnitude division truncates toward zero
        rem_d = fits_w ? trial_w[WORD_W-1:0] : {rem_q[WORD_W-2:0], quo_q[WORD_W-1]};
        quo_d = {quo_q[WORD_W-2:0], fits_w};
      end
      default: begin
        rem_d = rem_q;
        quo_d = quo_q;
      end
    endcase
  end

  // sequencing: state, step counter and busy
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      step_q  <= 5'h00;
      busy_o  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (div_go_w) begin
            step_q  <= 5'h00;
            busy_o  <= 1'b1;
            state_q <= ST_DIV;
          end
        end
        ST_DIV: begin
          step_q <= step_q + 5'h01;
          if (step_q == `DIV_STEPS - 5'h01) begin
            state_q <= ST_FIN;
          end
        end
        ST_FIN: begin
          busy_o  <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          busy_o  <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // divide operands captured at the taking edge
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_q   <= 2'h0;
      rem_q  <= {WORD_W{1'b0}};
      quo_q  <= {WORD_W{1'b0}};
      dvs_q  <= {WORD_W{1'b0}};
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
      a2_q   <= {WORD_W{1'b0}};
      a3_q   <= {WORD_W{1'b0}};
    end else begin
      rem_q <= rem_d;
      quo_q <= quo_d;
      if (take_w) begin
        op_q   <= op_i;
        dvs_q  <= vmag_w;
        qneg_q <= dneg_w ^ vneg_w;
        rneg_q <= dneg_w;
        a2_q   <= acc2_i;
        a3_q   <= acc3_i;
      end
    end
  end

  // results: all four accumulators and carry, written back on done_o
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o  <= 1'b0;
      acc0_o  <= {WORD_W{1'b0}};
      acc1_o  <= {WORD_W{1'b0}};
      acc2_o  <= {WORD_W{1'b0}};
      acc3_o  <= {WORD_W{1'b0}};
      carry_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (shift_w) begin
        acc0_o  <= shv_w[0];
        acc1_o  <= shv_w[1];
        acc2_o  <= shv_w[2];
        acc3_o  <= shv_w[3];
        carry_o <= carry_i;
        done_o  <= 1'b1;
      end else if (ovf_w) begin
        // overflow: all operands returned as they came in
        acc0_o  <= acc0_i;
        acc1_o  <= acc1_i;
        acc2_o  <= acc2_i;
        acc3_o  <= acc3_i;
        carry_o <= 1'b1;
        done_o  <= 1'b1;
      end else if (state_q == ST_FIN) begin
        acc0_o  <= rem_res_w;
        acc1_o  <= quo_res_w;
        acc2_o  <= a2_q;
        acc3_o  <= a3_q;
        carry_o <= sovf_w;
        done_o  <= 1'b1;
      end
    end
  end
endmodule

// ===== test/divshift_assertions.sv
/* port assertions for the divide and shift unit; bound to each instance */
`timescale 1ns/1ns
module divshift_assertions #(parameter WORD_W = 16) (
  input wire              ref_clk_i, rstn_i, start_i, carry_i, busy_o, done_o, carry_o,
  input wire [1:0]        op_i, src_sel_i, dst_sel_i,
  input wire [WORD_W-1:0] acc0_i, acc1_i, acc2_i, acc3_i, acc0_o, acc1_o, acc2_o, acc3_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [WORD_W-1:0] ai [4], ao [4];
  assign ai = '{acc0_i, acc1_i, acc2_i, acc3_i};
  assign ao = '{acc0_o, acc1_o, acc2_o, acc3_o};
  // a start in a divide's last cycle is dropped, so leave it out
  wire go = start_i && !busy_o && !done_o;
  wire sh = go && op_i == 2'h3;
  wire ud = go && !op_i && acc0_i < acc2_i;
  wire uo = go && !op_i && acc0_i >= acc2_i;
  wire [1:0] lo = dst_sel_i + 2'h1;
  wire [WORD_W-1:0] hv = ai[dst_sel_i], lv = ai[lo], sv = ai[src_sel_i];
  wire big = sv[7] ? sv[7:0] < 8'he1 : sv[7:0] > 8'h1f;
  AST_SH_CARRY: assert property (sh |=> done_o && carry_o == $past(carry_i))
    else $error("shift carry");
  AST_SH_CLEAR: assert property (sh && big |=> !ao[$past(dst_sel_i)] && !ao[$past(lo)])
    else $error("shift clear");
  AST_SH_ONE: assert property (sh && sv[7:0] == 8'h01 |=>
    {ao[$past(dst_sel_i)], ao[$past(lo)]} == {$past(hv), $past(lv)} << 1) else $error("shift");
  AST_SH_SRC: assert property (sh && src_sel_i != dst_sel_i && src_sel_i != lo |=>
    ao[$past(src_sel_i)] == $past(sv)) else $error("shift source");
  AST_UD_OVF: assert property (uo |=> done_o && carry_o && acc0_o == $past(acc0_i))
    else $error("overflow");
  AST_UD_KEEP: assert property (uo |=> acc1_o == $past(acc1_i))
    else $error("overflow keep");
  AST_UD_OK: assert property (ud |=> busy_o [*8] ##10
    done_o && !carry_o && acc2_o == $past(acc2_i, 18)) else $error("divide");
  AST_DIVZ: assert property (go && op_i != 2'h3 && !acc2_i |=> done_o && carry_o)
    else $error("zero divisor");
  cover property (sh && big);
  cover property (go && op_i == 2'h2);
  cover property (done_o && carry_o);
endmodule
bind divide_and_double_shift_unit divshift_assertions #(.WORD_W(WORD_W)) chk (.*);

// ===== test/acc_seq.sv
/* sequencer model: one operation at a time; assumes done_o answers each */
`timescale 1ns/1ns
module acc_seq (
  input  wire        clk_i,
  input  wire        done_i,
  input  wire [64:0] res_i,
  output reg         start_o = 1'b0,
  output reg  [5:0]  sel_o   = 6'h00,
  output reg  [64:0] acc_o   = 65'h0
);
  // file written only at done, so operands hold while busy
  task run(input [5:0] s, input [64:0] v);
    integer n;
    begin
      @(posedge clk_i);
      start_o <= 1'b1;
      sel_o   <= s;
      acc_o   <= v;
      @(posedge clk_i);
      start_o <= 1'b0;
      n = 0;
      do begin
        @(negedge clk_i);
        n = n + 1;
      end while (done_i !== 1'b1 && n < 40);
      @(posedge clk_i);
      acc_o <= res_i;
      @(negedge clk_i);
    end
  endtask
endmodule

// ===== test/divide_and_double_shift_unit_tb_top.sv
/* directed bench for the divide and shift unit; drives it through acc_seq */
`timescale 1ns/1ns
module divide_and_double_shift_unit_tb_top;
  reg         ref_clk_i = 1'b0;
  reg         rstn_i    = 1'b0;
  wire        start, busy_o, done_o;
  wire [5:0]  s;
  wire [64:0] a, r;
  integer     n_mismatch = 0, check_count = 0, cycles = 0;
  localparam [64:0] CY = {1'b1, 64'h0};
  always #5 ref_clk_i = ~ref_clk_i;
  divide_and_double_shift_unit uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start),
    .op_i(s[5:4]), .src_sel_i(s[3:2]), .dst_sel_i(s[1:0]), .carry_i(a[64]), .acc0_i(a[63:48]),
    .acc1_i(a[47:32]), .acc2_i(a[31:16]), .acc3_i(a[15:0]), .busy_o(busy_o), .done_o(done_o),
    .carry_o(r[64]), .acc0_o(r[63:48]), .acc1_o(r[47:32]), .acc2_o(r[31:16]), .acc3_o(r[15:0]));
  acc_seq sq (.clk_i(ref_clk_i), .done_i(done_o), .res_i(r), .start_o(start), .sel_o(s),
    .acc_o(a));
  task chk(input [5:0] c, input [64:0] v, e, input [64:0] m = {65{1'b1}});
    sq.run(c, v);
    check_count = check_count + 1;
    if ((a & m) !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("Error accumulators exp %h got %h", e, a & m);
    end
  endtask
  task t_udiv;
    chk(6'h00, 65'h10000000700025a5a, 65'h00001000300025a5a);
    chk(6'h00, 65'h00002000100020000, 65'h10002000100020000);
  endtask
  task t_sdiv;
    chk(6'h10, 65'h0fffffff9fffe0000, 65'h0ffff0003fffe0000);
    chk(6'h10, 65'h0ffff800000010000, 65'h00000800000010000);
    chk(6'h10, 65'h00000800000010000, CY, CY);
  endtask
  task t_sign_extend_then_divide;
    chk(6'h20, 65'h01234fff900020000, 65'h0fffffffd00020000);
    chk(6'h20, 65'h01234000700020000, 65'h00001000300020000);
    chk(6'h20, 65'h00000800000000000, CY, CY);
  endtask
  task t_shift;
    chk(6'h31, 65'h1000114e558d10000, 65'h1000129cab1a20000);
    chk(6'h31, 65'h000ff29cab1a20000, 65'h000ff14e558d10000);
    chk(6'h3b, 65'h08001000000104000, 65'h00000000000108001);
    chk(6'h38, 65'h11111222200203333, 65'h10000000000203333);
  endtask
  task summarize;
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_udiv;
    t_sdiv;
    t_sign_extend_then_divide;
    t_shift;
    summarize;
  end
endmodule
